// file: rtl/cpmic_top.sv
// Power modes, clock gating, interrupt flags and configuration with AHB-Lite
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module cpmic_top #(
  parameter int unsigned NUM_BUF = cpmic_pkg::CPMIC_NUM_BUF
) (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic               frame_active,
  input  wire logic               buffer_xfer_active,
  input  wire logic               tx_pending,
  input  wire logic               bus_idle,
  input  wire logic               bus_off_state,
  input  wire logic               bit_tick,
  input  wire logic [NUM_BUF-1:0] buf_done,
  input  wire logic               busoff_event,
  input  wire logic               error_event,
  input  wire logic               breakpoint_input,
  input  wire logic               can_rx,
  input  wire logic               core_tx,
  output logic                    can_tx,
  output logic                    core_rx,
  output logic                    comm_enable,
  output logic                    gated_clk,
  output logic                    clocks_gated,
  output logic [NUM_BUF-1:0]      buf_irq,
  output logic                    busoff_irq,
  output logic                    error_irq,
  output logic                    wakeup_irq
);
  import cpmic_pkg::*;

  // Bus slave: address phase capture
  logic         dphase_ff;
  logic         dwrite_ff;
  logic [7:0]   daddr_ff;
  logic         addr_take;

  assign addr_take = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dphase_ff <= 1'b0;
      dwrite_ff <= 1'b0;
      daddr_ff  <= 8'h00;
    end else if (hready) begin
      dphase_ff <= addr_take;
      dwrite_ff <= hwrite;
      daddr_ff  <= {haddr[7:2], 2'b00};
    end
  end

  logic wr_mcr;
  logic wr_pwr;
  logic wr_ctrl0;
  logic wr_error_status;
  logic wr_buffer_interrupt_enables;
  logic wr_buffer_event_flags;
  logic rd_error_status;
  logic rd_buffer_event_flags;
  logic dvalid;

  assign dvalid   = dphase_ff & hready;
  assign wr_mcr   = dvalid & dwrite_ff & (daddr_ff == CPMIC_OFS_MCR);
  assign wr_pwr   = dvalid & dwrite_ff & (daddr_ff == CPMIC_OFS_PWR);
  assign wr_ctrl0 = dvalid & dwrite_ff & (daddr_ff == CPMIC_OFS_CTRL0);
  assign wr_error_status = dvalid & dwrite_ff & (daddr_ff == CPMIC_OFS_ERROR_STATUS);
  assign wr_buffer_interrupt_enables = dvalid & dwrite_ff & (daddr_ff == CPMIC_OFS_BUFFER_INTERRUPT_ENABLES);
  assign wr_buffer_event_flags = dvalid & dwrite_ff & (daddr_ff == CPMIC_OFS_BUFFER_EVENT_FLAGS);
  assign rd_error_status = dvalid & !dwrite_ff & (daddr_ff == CPMIC_OFS_ERROR_STATUS);
  assign rd_buffer_event_flags = dvalid & !dwrite_ff & (daddr_ff == CPMIC_OFS_BUFFER_EVENT_FLAGS);

  // Configuration and control registers
  logic               sleep_ff;
  logic               frz_ff;
  logic               halt_ff;
  logic               wakeup_irq_enable_ff;
  logic               nrdy_ff;
  logic               aps_ff;
  logic               awake_ff;
  logic               boff_en_ff;
  logic               err_en_ff;
  logic [NUM_BUF-1:0] buffer_interrupt_enables_ff;
  logic               self_wake;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_ff   <= CPMIC_SLEEP_RST;
      frz_ff     <= CPMIC_FRZ_RST;
      halt_ff    <= CPMIC_HALT_RST;
      wakeup_irq_enable_ff <= CPMIC_WAKEUP_IRQ_ENABLE_RST;
    end else if (wr_mcr) begin
      // Any value is taken as written; not-ready and bit 13 are not stored
      sleep_ff   <= hwdata[CPMIC_MCR_SLEEP];
      frz_ff     <= hwdata[CPMIC_MCR_FRZ];
      halt_ff    <= hwdata[CPMIC_MCR_HALT];
      wakeup_irq_enable_ff <= hwdata[CPMIC_MCR_WAKEUP_IRQ_ENABLE];
    end else if (self_wake && awake_ff) begin
      sleep_ff   <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aps_ff   <= 1'b0;
      awake_ff <= 1'b0;
    end else if (wr_pwr) begin
      aps_ff   <= hwdata[CPMIC_PWR_APS];
      awake_ff <= hwdata[CPMIC_PWR_AWAKE];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      boff_en_ff <= 1'b0;
      err_en_ff  <= 1'b0;
    end else if (wr_ctrl0) begin
      boff_en_ff <= hwdata[CPMIC_CTRL0_BOFF_EN];
      err_en_ff  <= hwdata[CPMIC_CTRL0_ERR_EN];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_interrupt_enables_ff <= '0;
    end else if (wr_buffer_interrupt_enables) begin
      buffer_interrupt_enables_ff <= hwdata[NUM_BUF-1:0];
    end
  end

  // Mode sequencer
  cpmic_state_t state_ff;
  cpmic_state_t nxt_state;
  logic [3:0]   rcnt_ff;
  logic         rx_prev_ff;
  logic         dbg_req;
  logic         quiet;
  logic         offline;

  assign dbg_req   = frz_ff & (halt_ff | breakpoint_input);
  assign quiet     = bus_idle & !frame_active & !buffer_xfer_active;
  assign self_wake = (state_ff == CPMIC_ST_SLEEP) & rx_prev_ff & !can_rx;
  assign offline   = (state_ff == CPMIC_ST_DEBUG) |
                     (state_ff == CPMIC_ST_SLEEP);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      CPMIC_ST_SYNC: begin
        if (sleep_ff && quiet) begin
          nxt_state = CPMIC_ST_SLEEP;
        end else if (dbg_req && quiet) begin
          nxt_state = CPMIC_ST_DEBUG;
        end else if (bit_tick && can_rx &&
                     rcnt_ff == CPMIC_RESYNC_BITS - 4'h1) begin
          nxt_state = CPMIC_ST_RUN;
        end
      end
      CPMIC_ST_RUN: begin
        if (sleep_ff && quiet) begin
          nxt_state = CPMIC_ST_SLEEP;
        end else if (dbg_req && quiet) begin
          nxt_state = CPMIC_ST_DEBUG;
        end
      end
      CPMIC_ST_DEBUG: begin
        // A sleep request leaves debug through SYNC; from there sleep is entered as soon as the bus is quiet, without waiting for resynchronisation
        if (sleep_ff || !dbg_req) begin
          nxt_state = CPMIC_ST_SYNC;
        end
      end
      CPMIC_ST_SLEEP: begin
        if (self_wake && awake_ff) begin
          nxt_state = CPMIC_ST_RUN;
        end else if (!sleep_ff) begin
          nxt_state = CPMIC_ST_SYNC;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= CPMIC_ST_DEBUG;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Counts consecutive recessive bit times while resynchronising
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_ff <= 4'h0;
    end else if (state_ff != CPMIC_ST_SYNC) begin
      rcnt_ff <= 4'h0;
    end else if (bit_tick) begin
      rcnt_ff <= can_rx ? rcnt_ff + 4'h1 : 4'h0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= can_rx;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nrdy_ff <= 1'b1;
    end else begin
      nrdy_ff <= (nxt_state != CPMIC_ST_RUN);
    end
  end

  // Pin isolation and traffic enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      can_tx      <= 1'b1;
      core_rx     <= 1'b1;
      comm_enable <= 1'b0;
    end else begin
      can_tx      <= (offline || halt_ff) ? 1'b1 : core_tx;
      core_rx     <= offline ? 1'b1 : can_rx;
      comm_enable <= (state_ff == CPMIC_ST_RUN) & !halt_ff;
    end
  end

  // Event flags with read-then-write-one clearing
  logic [NUM_BUF-1:0] buffer_event_flags_ff;
  logic [NUM_BUF-1:0] iarm_ff;
  logic [2:0]         error_status_ff;
  logic [2:0]         earm_ff;
  logic [2:0]         eset;
  logic [NUM_BUF-1:0] nxt_buffer_event_flags;
  logic [2:0]         nxt_error_status;

  assign eset = {busoff_event, error_event, self_wake};

  always_comb begin
    nxt_buffer_event_flags = buffer_event_flags_ff;
    if (wr_buffer_event_flags && halt_ff) begin
      nxt_buffer_event_flags = hwdata[NUM_BUF-1:0];
    end else if (wr_buffer_event_flags) begin
      nxt_buffer_event_flags = buffer_event_flags_ff & ~(hwdata[NUM_BUF-1:0] & iarm_ff);
    end
    nxt_buffer_event_flags = nxt_buffer_event_flags | buf_done;
  end

  always_comb begin
    nxt_error_status = error_status_ff;
    if (wr_error_status && halt_ff) begin
      nxt_error_status = hwdata[2:0];
    end else if (wr_error_status) begin
      nxt_error_status = error_status_ff & ~(hwdata[2:0] & earm_ff);
    end
    nxt_error_status = nxt_error_status | eset;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_event_flags_ff <= '0;
      error_status_ff <= 3'h0;
    end else begin
      buffer_event_flags_ff <= nxt_buffer_event_flags;
      error_status_ff <= nxt_error_status;
    end
  end

  // A bit is armed by a read that saw it set; a new event or a write disarms
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      iarm_ff <= '0;
    end else if (rd_buffer_event_flags) begin
      iarm_ff <= buffer_event_flags_ff & ~buf_done;
    end else if (wr_buffer_event_flags) begin
      iarm_ff <= '0;
    end else begin
      iarm_ff <= iarm_ff & ~buf_done;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      earm_ff <= 3'h0;
    end else if (rd_error_status) begin
      earm_ff <= error_status_ff & ~eset;
    end else if (wr_error_status) begin
      earm_ff <= 3'h0;
    end else begin
      earm_ff <= earm_ff & ~eset;
    end
  end

  // Interrupt requests, one per source
  assign buf_irq    = buffer_event_flags_ff & buffer_interrupt_enables_ff;
  assign busoff_irq = error_status_ff[CPMIC_ES_BOFF] & boff_en_ff;
  assign error_irq  = error_status_ff[CPMIC_ES_ERR] & err_en_ff;
  assign wakeup_irq = error_status_ff[CPMIC_ES_WAKE] & wakeup_irq_enable_ff;

  // Clock gating
  logic bus_access;
  logic aps_idle;
  logic gate_on;
  logic clk_en_lo_ff;

  assign bus_access = (hsel & htrans[1]) | dphase_ff;
  assign aps_idle   = aps_ff & !frame_active & !buffer_xfer_active &
                      !tx_pending & !bus_access & !bus_off_state &
                      (state_ff == CPMIC_ST_RUN);
  assign gate_on    = aps_idle | ((state_ff == CPMIC_ST_SLEEP) &
                      !bus_access);

  // Enable changes only while the clock is low, so the AND cannot glitch
  always_ff @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_en_lo_ff <= 1'b1;
    end else begin
      clk_en_lo_ff <= !gate_on;
    end
  end

  assign gated_clk    = core_clk & clk_en_lo_ff;
  assign clocks_gated = !clk_en_lo_ff;

  // Read data during the data phase
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dphase_ff && !dwrite_ff) begin
      unique case (daddr_ff)
        CPMIC_OFS_MCR: begin
          hrdata[CPMIC_MCR_SLEEP]   = sleep_ff;
          hrdata[CPMIC_MCR_FRZ]     = frz_ff;
          hrdata[CPMIC_MCR_HALT]    = halt_ff;
          hrdata[CPMIC_MCR_NRDY]    = nrdy_ff;
          hrdata[CPMIC_MCR_WAKEUP_IRQ_ENABLE] = wakeup_irq_enable_ff;
        end
        CPMIC_OFS_PWR: begin
          hrdata[CPMIC_PWR_APS]   = aps_ff;
          hrdata[CPMIC_PWR_AWAKE] = awake_ff;
        end
        CPMIC_OFS_STAT: begin
          hrdata[CPMIC_STAT_GATED] = !clk_en_lo_ff;
          hrdata[CPMIC_STAT_DEBUG] = (state_ff == CPMIC_ST_DEBUG);
          hrdata[CPMIC_STAT_SLEEP] = (state_ff == CPMIC_ST_SLEEP);
        end
        CPMIC_OFS_CTRL0: begin
          hrdata[CPMIC_CTRL0_BOFF_EN] = boff_en_ff;
          hrdata[CPMIC_CTRL0_ERR_EN]  = err_en_ff;
        end
        CPMIC_OFS_ERROR_STATUS: hrdata[2:0]         = error_status_ff;
        CPMIC_OFS_BUFFER_INTERRUPT_ENABLES: hrdata[NUM_BUF-1:0] = buffer_interrupt_enables_ff;
        CPMIC_OFS_BUFFER_EVENT_FLAGS: hrdata[NUM_BUF-1:0] = buffer_event_flags_ff;
        default:         hrdata = 32'h0000_0000;
      endcase
    end
  end

endmodule : cpmic_top

// file: rtl/cpmic_pkg.sv
// Package: register map, fields, reset values and states of the CAN power block
// Operation
// - With auto power save on, gate clocks only when fully idle and running.
// - Ungate as soon as any idle condition fails; keep gating and ungating.
// - Nineteen interrupt sources: sixteen buffers plus bus-off, error, wake-up.
// - A buffer requests an interrupt only when its enable bit is set.
// - One flag per buffer, set on transmit or receive success alike.
// - Flag clears by read while set, then write one; new event blocks clear.
// - Bus-off, error, wake-up flags in error status behave the same way.
// - Bus-off and error enables in control zero; wake enable in configuration.
// - No protection against any programming; every value is accepted.
// - Setting halt after synchronisation makes the not-ready bit set.
// - Bit 15 sleep: one stops clocks; CPU sets, CPU or self-wake clears.
// - Bit 14 freeze enable gates halt and breakpoint; clearing leaves debug.
// - Bit 12 halt, reset to one, acts as breakpoint; traffic off until cleared.
// - While halt is set, normally read-only flag bits become writable.
// - Bit 11 not-ready is set in sleep or debug, cleared on leaving; here it stays set through resynchronisation until run.
// - Bit 10 wake-up interrupt enable: one enables, zero disables.
// - In sleep a recessive-to-dominant edge sets the wake flag.
// - In debug or sleep ignore receive, drive transmit recessive, stop frames.
// - After leaving debug wait eleven recessive bits before joining the bus.
package cpmic_pkg;

  localparam int unsigned CPMIC_NUM_BUF = 16;

  localparam logic [7:0] CPMIC_OFS_MCR   = 8'h00;
  localparam logic [7:0] CPMIC_OFS_PWR   = 8'h04;
  localparam logic [7:0] CPMIC_OFS_STAT  = 8'h08;
  localparam logic [7:0] CPMIC_OFS_CTRL0 = 8'h0C;
  localparam logic [7:0] CPMIC_OFS_ERROR_STATUS = 8'h10;
  localparam logic [7:0] CPMIC_OFS_BUFFER_INTERRUPT_ENABLES = 8'h14;
  localparam logic [7:0] CPMIC_OFS_BUFFER_EVENT_FLAGS = 8'h18;

  localparam int unsigned CPMIC_MCR_SLEEP   = 15;
  localparam int unsigned CPMIC_MCR_FRZ     = 14;
  localparam int unsigned CPMIC_MCR_HALT    = 12;
  localparam int unsigned CPMIC_MCR_NRDY    = 11;
  localparam int unsigned CPMIC_MCR_WAKEUP_IRQ_ENABLE = 10;

  localparam int unsigned CPMIC_PWR_APS   = 0;
  localparam int unsigned CPMIC_PWR_AWAKE = 1;

  localparam int unsigned CPMIC_STAT_GATED = 0;
  localparam int unsigned CPMIC_STAT_DEBUG = 1;
  localparam int unsigned CPMIC_STAT_SLEEP = 2;

  localparam int unsigned CPMIC_CTRL0_BOFF_EN = 15;
  localparam int unsigned CPMIC_CTRL0_ERR_EN  = 14;

  localparam int unsigned CPMIC_ES_WAKE = 0;
  localparam int unsigned CPMIC_ES_ERR  = 1;
  localparam int unsigned CPMIC_ES_BOFF = 2;

  localparam logic CPMIC_SLEEP_RST   = 1'b0;
  localparam logic CPMIC_FRZ_RST     = 1'b1;
  localparam logic CPMIC_HALT_RST    = 1'b1;
  localparam logic CPMIC_WAKEUP_IRQ_ENABLE_RST = 1'b0;

  localparam logic [3:0] CPMIC_RESYNC_BITS = 4'hB;

  typedef enum logic [1:0] {
    CPMIC_ST_DEBUG = 2'b00,
    CPMIC_ST_SYNC  = 2'b01,
    CPMIC_ST_RUN   = 2'b11,
    CPMIC_ST_SLEEP = 2'b10
  } cpmic_state_t;

endpackage : cpmic_pkg

// file: tb/cpmic_assertions.sv
// Checker: port-level properties of the CAN power block
`timescale 1ns/1ps
module cpmic_checker #(
  parameter int unsigned NUM_BUF = 16
) (
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               hsel,
  input wire logic [1:0]         htrans,
  input wire logic               hready,
  input wire logic               hwrite,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic [31:0]        hrdata,
  input wire logic               can_rx,
  input wire logic               core_rx,
  input wire logic               comm_enable,
  input wire logic               clocks_gated,
  input wire logic [NUM_BUF-1:0] buf_done,
  input wire logic [NUM_BUF-1:0] buf_irq,
  input wire logic               busoff_irq,
  input wire logic               error_irq
);
  logic wr_dp_ff;
  logic rd_dp_ff;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Marks the data phase of each accepted transfer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_dp_ff <= 1'b0;
      rd_dp_ff <= 1'b0;
    end else begin
      wr_dp_ff <= hsel && htrans[1] && hready && hwrite;
      rd_dp_ff <= hsel && htrans[1] && hready && !hwrite;
    end
  end

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_read_idle: assert property (!rd_dp_ff |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  a_bufirq_cause: assert property ((buf_irq & ~$past(buf_irq)) != '0
    |-> ($past(buf_done) != '0) || $past(wr_dp_ff))
    else $error("buffer request rose without event or write");
  a_bufirq_hold: assert property ((~buf_irq & $past(buf_irq)) != '0
    |-> $past(wr_dp_ff))
    else $error("buffer request dropped without a write");
  a_err_hold: assert property ($fell(busoff_irq) || $fell(error_irq)
    |-> $past(wr_dp_ff))
    else $error("status request dropped without a write");
  a_gate_access: assert property (hsel && htrans[1] && hready
    |-> ##[0:2] !clocks_gated)
    else $error("clock still gated during a bus access");
  a_gate_start: assert property ($rose(clocks_gated)
    |-> !(hsel && htrans[1]))
    else $error("clock gated while a bus access was pending");
  a_rx_follow: assert property (comm_enable
    |-> core_rx == $past(can_rx))
    else $error("receive path not following the bus");
endmodule : cpmic_checker

// file: tb/cpmic_bus_node.sv
// Partner: another node on the wired-AND CAN bus
`timescale 1ns/1ps
module cpmic_bus_node #(
  parameter int unsigned BIT_CYC = 5
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic send_sof,
  input  wire logic can_tx,
  output logic      can_rx,
  output logic      bit_tick
);
  logic [3:0] cyc_ff;
  logic [3:0] dom_ff;

  // A dominant level from either node wins on the bus
  assign can_rx   = can_tx & (dom_ff == 4'h0);
  assign bit_tick = (cyc_ff == 4'h0);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_ff <= 4'h0;
    end else begin
      cyc_ff <= (cyc_ff == 4'(BIT_CYC - 1)) ? 4'h0 : cyc_ff + 4'h1;
    end
  end

  // Start of frame: one dominant bit, then recessive again
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dom_ff <= 4'h0;
    end else if (send_sof) begin
      dom_ff <= 4'(BIT_CYC);
    end else if (dom_ff != 4'h0) begin
      dom_ff <= dom_ff - 4'h1;
    end
  end
endmodule : cpmic_bus_node

// file: tb/cpmic_top_test.sv
// Testbench: registers, flags, modes and gating of the CAN power block
`timescale 1ns/1ps
module cpmic_top_test;
  import cpmic_pkg::*;
  logic        core_clk     = 1'b0;
  logic        rst_n        = 1'b0;
  logic        hsel         = 1'b0;
  logic [31:0] haddr        = 32'h0;
  logic [1:0]  htrans       = 2'b00;
  logic        hwrite       = 1'b0;
  logic [31:0] hwdata       = 32'h0;
  logic        frame_active = 1'b0;
  logic        tx_pending   = 1'b0;
  logic        bus_idle     = 1'b1;
  logic [15:0] buf_done     = 16'h0;
  logic        busoff_event = 1'b0;
  logic        error_event  = 1'b0;
  logic        core_tx      = 1'b1;
  logic        send_sof     = 1'b0;
  logic        buffer_xfer_active = 1'b0;
  logic        bus_off_state      = 1'b0;
  logic        breakpoint_input   = 1'b0;
  logic        core_rx;
  logic        gated_clk;
  int          gclk_n       = 0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        bit_tick;
  logic        can_rx;
  logic        can_tx;
  logic        comm_enable;
  logic        clocks_gated;
  logic [15:0] buf_irq;
  logic        busoff_irq;
  logic        error_irq;
  logic        wakeup_irq;
  int          errors       = 0;
  int          checks       = 0;
  int          cyc          = 0;

  cpmic_top #(.NUM_BUF(16)) cpmic_top_inst (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .frame_active(frame_active),
    .buffer_xfer_active(buffer_xfer_active), .tx_pending(tx_pending),
    .bus_idle(bus_idle), .bus_off_state(bus_off_state),
    .bit_tick(bit_tick),
    .buf_done(buf_done), .busoff_event(busoff_event),
    .error_event(error_event), .breakpoint_input(breakpoint_input),
    .can_rx(can_rx), .core_tx(core_tx), .can_tx(can_tx),
    .core_rx(core_rx),
    .comm_enable(comm_enable), .gated_clk(gated_clk),
    .clocks_gated(clocks_gated),
    .buf_irq(buf_irq), .busoff_irq(busoff_irq), .error_irq(error_irq),
    .wakeup_irq(wakeup_irq)
  );

  cpmic_bus_node #(.BIT_CYC(5)) cpmic_bus_node_inst (
    .core_clk(core_clk), .rst_n(rst_n), .send_sof(send_sof),
    .can_tx(can_tx), .can_rx(can_rx), .bit_tick(bit_tick)
  );

  // Counts edges of the gated clock
  always @(posedge gated_clk) gclk_n++;

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_rdy(output logic [31:0] d);
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    logic [31:0] nul;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy(nul);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(rd);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] nul;
    bus(1'b1, a, d, nul);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask : rdc

  task automatic poll(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] v);
    logic [31:0] r;
    int i;
    r = ~v;
    for (i = 0; i < 200 && (r & m) !== v; i++) bus(1'b0, a, 32'h0, r);
    chk(r & m, v);
  endtask : poll

  task automatic wgate(input logic v);
    int i;
    for (i = 0; i < 20 && clocks_gated !== v; i++) @(posedge core_clk);
    chk(clocks_gated, v);
  endtask : wgate

  task automatic pulse(input logic [15:0] b, input logic bo,
                       input logic er);
    buf_done <= b;
    busoff_event <= bo;
    error_event <= er;
    @(posedge core_clk);
    buf_done <= 16'h0;
    busoff_event <= 1'b0;
    error_event <= 1'b0;
    @(posedge core_clk);
  endtask : pulse

  task automatic t_reset();
    rdc(CPMIC_OFS_MCR, 32'h0000_5800);
    rdc(CPMIC_OFS_STAT, 32'h0000_0002);
    rdc(8'h1C, 32'h0000_0000);
    chk(can_tx, 1'b1);
  endtask : t_reset

  task automatic t_config();
    wr(CPMIC_OFS_MCR, 32'h0000_6C00);
    poll(CPMIC_OFS_MCR, 32'h0000_0800, 32'h0);
    rdc(CPMIC_OFS_MCR, 32'h0000_4400);
    chk(comm_enable, 1'b1);
  endtask : t_config

  task automatic t_buf();
    wr(CPMIC_OFS_BUFFER_INTERRUPT_ENABLES, 32'h0000_0001);
    pulse(16'h0021, 1'b0, 1'b0);
    rdc(CPMIC_OFS_BUFFER_EVENT_FLAGS, 32'h0000_0021);
    chk(buf_irq, 16'h0001);
    pulse(16'h0020, 1'b0, 1'b0);
    wr(CPMIC_OFS_BUFFER_EVENT_FLAGS, 32'h0000_0021);
    rdc(CPMIC_OFS_BUFFER_EVENT_FLAGS, 32'h0000_0020);
    chk(buf_irq, 16'h0000);
    wr(CPMIC_OFS_BUFFER_EVENT_FLAGS, 32'h0000_0020);
    rdc(CPMIC_OFS_BUFFER_EVENT_FLAGS, 32'h0000_0000);
  endtask : t_buf

  task automatic t_err();
    wr(CPMIC_OFS_CTRL0, 32'h0000_C000);
    pulse(16'h0, 1'b1, 1'b1);
    chk({busoff_irq, error_irq}, 2'b11);
    wr(CPMIC_OFS_ERROR_STATUS, 32'h0000_0006);
    rdc(CPMIC_OFS_ERROR_STATUS, 32'h0000_0006);
    wr(CPMIC_OFS_ERROR_STATUS, 32'h0000_0006);
    rdc(CPMIC_OFS_ERROR_STATUS, 32'h0000_0000);
    chk({busoff_irq, error_irq}, 2'b00);
  endtask : t_err

  task automatic t_halt();
    wr(CPMIC_OFS_MCR, 32'h0000_5400);
    poll(CPMIC_OFS_MCR, 32'h0000_0800, 32'h0000_0800);
    core_tx <= 1'b0;
    send_sof <= 1'b1;
    @(posedge core_clk);
    send_sof <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(can_tx, 1'b1);
    chk(core_rx, 1'b1);
    core_tx <= 1'b1;
    wr(CPMIC_OFS_BUFFER_EVENT_FLAGS, 32'h0000_00F0);
    rdc(CPMIC_OFS_BUFFER_EVENT_FLAGS, 32'h0000_00F0);
    wr(CPMIC_OFS_BUFFER_EVENT_FLAGS, 32'h0);
    wr(CPMIC_OFS_MCR, 32'h0000_1400);
    poll(CPMIC_OFS_MCR, 32'h0000_0800, 32'h0);
    rdc(CPMIC_OFS_STAT, 32'h0);
    wr(CPMIC_OFS_MCR, 32'h0000_0400);
    breakpoint_input <= 1'b1;
    rdc(CPMIC_OFS_STAT, 32'h0);
    wr(CPMIC_OFS_MCR, 32'h0000_4400);
    poll(CPMIC_OFS_STAT, 32'h0000_0002, 32'h0000_0002);
    breakpoint_input <= 1'b0;
    poll(CPMIC_OFS_MCR, 32'h0000_0800, 32'h0);
  endtask : t_halt

  task automatic t_sleep();
    wr(CPMIC_OFS_PWR, 32'h0000_0002);
    wr(CPMIC_OFS_MCR, 32'h0000_8400);
    poll(CPMIC_OFS_STAT, 32'h0000_0004, 32'h0000_0004);
    wgate(1'b1);
    send_sof <= 1'b1;
    @(posedge core_clk);
    send_sof <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(wakeup_irq, 1'b1);
    poll(CPMIC_OFS_MCR, 32'h0000_8800, 32'h0);
    rdc(CPMIC_OFS_ERROR_STATUS, 32'h0000_0001);
  endtask : t_sleep

  task automatic t_aps();
    int n;
    wr(CPMIC_OFS_PWR, 32'h0000_0001);
    wgate(1'b1);
    n = gclk_n;
    repeat (3) @(posedge core_clk);
    chk(gclk_n - n, 32'h0);
    tx_pending <= 1'b1;
    wgate(1'b0);
    tx_pending <= 1'b0;
    wgate(1'b1);
    frame_active <= 1'b1;
    wgate(1'b0);
    frame_active <= 1'b0;
    wgate(1'b1);
    buffer_xfer_active <= 1'b1;
    wgate(1'b0);
    buffer_xfer_active <= 1'b0;
    wgate(1'b1);
    bus_off_state <= 1'b1;
    wgate(1'b0);
    bus_off_state <= 1'b0;
    wgate(1'b1);
    rdc(CPMIC_OFS_MCR, 32'h0000_0400);
  endtask : t_aps

  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_config();
    t_buf();
    t_err();
    t_halt();
    t_sleep();
    t_aps();
    tally_and_finish();
  end

  // Cuts a hung run short
  initial begin
    forever begin
      @(posedge core_clk);
      cyc++;
      if (cyc > 20000) begin
        errors++;
        tally_and_finish();
      end
    end
  end
endmodule : cpmic_top_test

bind cpmic_top cpmic_checker #(.NUM_BUF(NUM_BUF)) cpmic_checker_inst (
  .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
  .hready(hready), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .can_rx(can_rx), .core_rx(core_rx),
  .comm_enable(comm_enable), .clocks_gated(clocks_gated),
  .buf_done(buf_done), .buf_irq(buf_irq), .busoff_irq(busoff_irq),
  .error_irq(error_irq)
);
